// >>> logic/hpsc_regs.vh
// Register offsets, field positions, reset values and codes of the status scan chain.
`ifndef HPSC_REGS_VH
`define HPSC_REGS_VH

// Register byte addresses on the plain register port.
`define HPSC_ADDR_MODE      8'h00
`define HPSC_ADDR_CHAN      8'h04
`define HPSC_ADDR_IRQ_STAT  8'h08
`define HPSC_ADDR_IRQ_MASK  8'h0c

// Interrupt status and mask bit positions.
`define HPSC_IRQ_MODE_BIT   0
`define HPSC_IRQ_HDR_BIT    1
`define HPSC_IRQ_RSVD_BIT   2
`define HPSC_IRQ_WIDTH      3
`define HPSC_IRQ_RESET      3'h0

// Mode register field positions.
`define HPSC_MODE_CODE_LSB  0
`define HPSC_MODE_TEST_BIT  3
`define HPSC_MODE_PINS_LSB  4
`define HPSC_MODE_FRAME_BIT 6

// Latched operating modes.
`define HPSC_MODE_OFF       3'h0
`define HPSC_MODE_OPER      3'h1
`define HPSC_MODE_NAND      3'h2
`define HPSC_MODE_TRIST     3'h3
`define HPSC_MODE_RSVD      3'h4

// Channel addresses.
`define HPSC_CHAN_INT       2'h0
`define HPSC_CHAN_CAP       2'h1
`define HPSC_CHAN_DIAG1     2'h2
`define HPSC_CHAN_DIAG2     2'h3

// Frame layout and timing counts.
`define HPSC_SLOT_BITS      8
`define HPSC_FRAME_BITS     16
`define HPSC_SYNC_STAGES    2

`endif

// >>> logic/hpsc_scan_chain.v
// Status scan chain, mode latch and register port of the two-slot hot-plug controller.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "hpsc_regs.vh"

module hpsc_scan_chain (
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_write_in,
  input  wire        reg_read_in,
  output reg  [31:0] reg_rdata_out,
  output wire        irq_out,
  input  wire        main_power_valid_in,
  input  wire        test_select_in,
  input  wire        mode_pin_low_in,
  output wire        status_serial_out,
  output wire        status_serial_oe_out,
  input  wire        mode_pin_high_in,
  output wire        command_serial_out,
  output wire        command_serial_oe_out,
  input  wire        status_frame_line_in,
  input  wire        status_scan_clock_in,
  input  wire        status_cascade_in_in,
  input  wire [1:0]  interlock_open_in,
  input  wire [1:0]  button_pushed_in,
  input  wire [1:0]  main_fault_n_in,
  input  wire [1:0]  aux_fault_n_in,
  input  wire [1:0]  present1_in,
  input  wire [1:0]  present2_in,
  input  wire [1:0]  clk66_enable_in,
  input  wire [1:0]  xcap_above_gnd_in,
  input  wire [1:0]  xcap_open_in,
  input  wire [1:0]  power_enable_in,
  input  wire [1:0]  slot_clock_enable_in,
  input  wire [1:0]  slot_bus_enable_in,
  input  wire [1:0]  slot_reset_line_in,
  input  wire [1:0]  power_indicator_cmd_in,
  input  wire [1:0]  attention_indicator_cmd_in,
  output reg  [1:0]  power_indicator_out,
  output reg  [1:0]  attention_indicator_out,
  output wire        pins_tristate_out,
  output wire        nand_tree_mode_out
);

  localparam PIN_W = 25;

  // Frame sequencer states.
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR0 = 3'h1;
  localparam ST_ADDR1 = 3'h2;
  localparam ST_RSVD  = 3'h3;
  localparam ST_SHIFT = 3'h4;

  // Turns the three-level capability comparators into {bit2, bit1}.
  function [1:0] cap_decode;
    input above_gnd;
    input open_pin;
    begin
      cap_decode = {open_pin, above_gnd | open_pin};
    end
  endfunction

  // Builds one slot byte of the selected channel group.
  function [7:0] slot_byte;
    input [1:0] chan;
    input       sw;
    input       btn;
    input       flt_n;
    input       aux_n;
    input       p2;
    input       p1;
    input       m66;
    input [1:0] cap;
    input       pwr;
    input       clk_en;
    input       bus_en;
    input       rst_l;
    input       pled;
    input       aled;
    begin
      case (chan)
        `HPSC_CHAN_INT: begin
          slot_byte = {3'h0, p1, p2, flt_n, btn, sw};
        end
        `HPSC_CHAN_CAP: begin
          slot_byte = {4'h0, aux_n, cap[1], cap[0], m66};
        end
        `HPSC_CHAN_DIAG1: begin
          slot_byte = {1'b0, aled, pled, rst_l, bus_en, clk_en, pwr,
                       1'b1};
        end
        default: begin
          slot_byte = 8'h00;
        end
      endcase
    end
  endfunction

  // Every pin that comes from outside the clock domain passes two flip-flops.
  wire [PIN_W-1:0] pin_raw;
  reg  [PIN_W-1:0] pin_meta;
  reg  [PIN_W-1:0] pin_sync;

  assign pin_raw = {status_cascade_in_in, status_scan_clock_in, status_frame_line_in,
                    mode_pin_high_in, mode_pin_low_in, test_select_in, main_power_valid_in,
                    xcap_open_in, xcap_above_gnd_in, clk66_enable_in, present2_in,
                    present1_in, aux_fault_n_in, main_fault_n_in, button_pushed_in,
                    interlock_open_in};

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pin_meta <= {PIN_W{1'b0}};
      pin_sync <= {PIN_W{1'b0}};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire [1:0] s_sw    = pin_sync[1:0];
  wire [1:0] s_btn   = pin_sync[3:2];
  wire [1:0] s_mflt  = pin_sync[5:4];
  wire [1:0] s_aflt  = pin_sync[7:6];
  wire [1:0] s_p1    = pin_sync[9:8];
  wire [1:0] s_p2    = pin_sync[11:10];
  wire [1:0] s_m66   = pin_sync[13:12];
  wire [1:0] s_xgnd  = pin_sync[15:14];
  wire [1:0] s_xopen = pin_sync[17:16];
  wire       s_main_power_valid = pin_sync[18];
  wire       s_test  = pin_sync[19];
  wire       s_mlow  = pin_sync[20];
  wire       s_mhigh = pin_sync[21];
  wire       s_frame = pin_sync[22];
  wire       s_sclk  = pin_sync[23];
  wire       s_casc  = pin_sync[24];

  // Mode latch state and edge history of the synchronised pins.
  reg  [2:0] mode;
  reg  [1:0] mode_pins;
  reg        main_power_valid_q;
  reg        sclk_q;
  wire       main_power_valid_rise = s_main_power_valid & ~main_power_valid_q;
  wire       sclk_rise  = s_sclk & ~sclk_q;
  wire       sclk_fall  = ~s_sclk & sclk_q;
  wire       oper       = (mode == `HPSC_MODE_OPER) & s_main_power_valid;
  reg  [2:0] next_mode;

  // Decode of the mode pins at the rising edge of power valid.
  always @* begin
    next_mode = `HPSC_MODE_RSVD;
    if (!s_test && s_mhigh && s_mlow) begin
      next_mode = `HPSC_MODE_OPER;
    end else if (s_test && !s_mhigh && !s_mlow) begin
      next_mode = `HPSC_MODE_NAND;
    end else if (s_test && !s_mhigh && s_mlow) begin
      next_mode = `HPSC_MODE_TRIST;
    end
  end

  // The mode pins are undriven while the mode is off, so the latch sees the straps only.
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mode      <= `HPSC_MODE_OFF;
      mode_pins <= 2'h0;
      main_power_valid_q   <= 1'b0;
      sclk_q    <= 1'b0;
    end else begin
      main_power_valid_q <= s_main_power_valid;
      sclk_q  <= s_sclk;
      if (main_power_valid_rise) begin
        mode      <= next_mode;
        mode_pins <= {s_mhigh, s_mlow};
      end else if (!s_main_power_valid) begin
        mode <= `HPSC_MODE_OFF;
      end
    end
  end

  assign pins_tristate_out  = (mode == `HPSC_MODE_TRIST);
  assign nand_tree_mode_out = (mode == `HPSC_MODE_NAND);

  // The command chain is not built here; its pin is held low while it is driven.
  assign status_serial_oe_out  = oper;
  assign command_serial_oe_out = oper;
  assign command_serial_out    = 1'b0;

  // Slot bytes of the selected group for both slots, recomputed each cycle from the pins.
  wire [`HPSC_FRAME_BITS-1:0] chan_word;
  reg  [1:0]                  chan_sel;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_slot
      wire [1:0] cap = cap_decode(s_xgnd[g], s_xopen[g]);
      assign chan_word[g*`HPSC_SLOT_BITS +: `HPSC_SLOT_BITS] =
        slot_byte(chan_sel, s_sw[g], s_btn[g], s_mflt[g] & s_aflt[g], s_aflt[g],
                  s_p2[g], s_p1[g], s_m66[g], cap, power_enable_in[g],
                  slot_clock_enable_in[g], slot_bus_enable_in[g], slot_reset_line_in[g],
                  power_indicator_out[g], attention_indicator_out[g]);
    end
  endgenerate

  // Indicator drive: in run-time test the indicators show internal state instead.
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      power_indicator_out     <= 2'h0;
      attention_indicator_out <= 2'h0;
    end else if (s_main_power_valid && s_test && !pins_tristate_out) begin
      power_indicator_out     <= power_enable_in;
      attention_indicator_out <= ~(s_mflt & s_aflt);
    end else begin
      power_indicator_out     <= power_indicator_cmd_in;
      attention_indicator_out <= attention_indicator_cmd_in;
    end
  end

  // Frame sequencer: inputs are sampled on scan clock rising edges and the
  // chain moves on falling edges, so the controller sees stable data each rise.
  reg  [2:0]                  state;
  reg  [`HPSC_FRAME_BITS-1:0] shreg;
  reg                         casc_bit;
  reg                         shift_pend;
  reg                         addr_lsb;
  reg                         rsvd_bit;
  reg                         hdr_evt;

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state      <= ST_IDLE;
      shreg      <= {`HPSC_FRAME_BITS{1'b0}};
      casc_bit   <= 1'b0;
      shift_pend <= 1'b0;
      addr_lsb   <= 1'b0;
      rsvd_bit   <= 1'b0;
      chan_sel   <= `HPSC_CHAN_INT;
      hdr_evt    <= 1'b0;
    end else begin
      hdr_evt <= 1'b0;
      if (!oper) begin
        state      <= ST_IDLE;
        shift_pend <= 1'b0;
      end else if (sclk_rise) begin
        case (state)
          ST_IDLE: begin
            if (!s_frame) begin
              state <= ST_ADDR0;
            end
          end
          ST_ADDR0: begin
            addr_lsb <= s_frame;
            state    <= ST_ADDR1;
          end
          ST_ADDR1: begin
            chan_sel <= {s_frame, addr_lsb};
            state    <= ST_RSVD;
          end
          ST_RSVD: begin
            rsvd_bit <= s_frame;
            shreg    <= chan_word;
            hdr_evt  <= 1'b1;
            state    <= ST_SHIFT;
          end
          ST_SHIFT: begin
            if (!s_frame) begin
              state      <= ST_ADDR0;
              shift_pend <= 1'b0;
            end else begin
              casc_bit   <= s_casc;
              shift_pend <= 1'b1;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end else if (sclk_fall && shift_pend) begin
        shreg      <= {casc_bit, shreg[`HPSC_FRAME_BITS-1:1]};
        shift_pend <= 1'b0;
      end
    end
  end

  assign status_serial_out = shreg[0];

  // Sticky interrupt status; a new event in the clearing cycle wins over the clear.
  reg  [`HPSC_IRQ_WIDTH-1:0] irq_stat;
  reg  [`HPSC_IRQ_WIDTH-1:0] irq_mask;
  wire [`HPSC_IRQ_WIDTH-1:0] irq_evt;
  wire                       wr_stat = reg_write_in && (reg_addr_in == `HPSC_ADDR_IRQ_STAT);

  assign irq_evt[`HPSC_IRQ_MODE_BIT] = main_power_valid_rise && (next_mode == `HPSC_MODE_OPER);
  assign irq_evt[`HPSC_IRQ_HDR_BIT]  = hdr_evt;
  assign irq_evt[`HPSC_IRQ_RSVD_BIT] = main_power_valid_rise && (next_mode == `HPSC_MODE_RSVD);

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_stat <= `HPSC_IRQ_RESET;
      irq_mask <= `HPSC_IRQ_RESET;
    end else begin
      if (wr_stat) begin
        irq_stat <= (irq_stat & ~reg_wdata_in[`HPSC_IRQ_WIDTH-1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
      if (reg_write_in && (reg_addr_in == `HPSC_ADDR_IRQ_MASK)) begin
        irq_mask <= reg_wdata_in[`HPSC_IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

  // Read data stand for one cycle after the strobe; unmapped addresses read zero.
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        `HPSC_ADDR_MODE: begin
          reg_rdata_out <= {25'h0, state != ST_IDLE, mode_pins, s_test, mode};
        end
        `HPSC_ADDR_CHAN: begin
          reg_rdata_out <= {29'h0, rsvd_bit, chan_sel};
        end
        `HPSC_ADDR_IRQ_STAT: begin
          reg_rdata_out <= {29'h0, irq_stat};
        end
        `HPSC_ADDR_IRQ_MASK: begin
          reg_rdata_out <= {29'h0, irq_mask};
        end
        default: begin
          reg_rdata_out <= 32'h0;
        end
      endcase
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end

endmodule // hpsc_scan_chain

// >>> verification/hpsc_scan_chain_sva.sv
// Port checker of the status scan chain.
`timescale 1ns/10ps
module hpsc_scan_chain_chk (
  input wire       core_clk_in,
  input wire       rst_n_in,
  input wire       main_power_valid_in,
  input wire       test_select_in,
  input wire       mode_pin_low_in,
  input wire       mode_pin_high_in,
  input wire       status_serial_oe_out,
  input wire       command_serial_oe_out,
  input wire [1:0] main_fault_n_in,
  input wire [1:0] aux_fault_n_in,
  input wire [1:0] power_enable_in,
  input wire [1:0] power_indicator_out,
  input wire [1:0] attention_indicator_out,
  input wire       pins_tristate_out,
  input wire       nand_tree_mode_out
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Pin patterns; held long enough to clear the synchronisers.
  wire pv   = main_power_valid_in;
  wire p_op = !test_select_in && mode_pin_low_in && mode_pin_high_in;
  wire p_tr = test_select_in && mode_pin_low_in && !mode_pin_high_in;
  wire p_nd = test_select_in && !mode_pin_low_in && !mode_pin_high_in;
  wire run_tst = pv && test_select_in && !pins_tristate_out && !nand_tree_mode_out;

  chk_oe_pair: assert property (
    status_serial_oe_out == command_serial_oe_out) else $error("oe pair differs");
  chk_oe_off: assert property (
    !pv [*5] |-> !status_serial_oe_out) else $error("oe without power");
  chk_oe_excl: assert property (
    status_serial_oe_out |-> !pins_tristate_out && !nand_tree_mode_out) else $error("oe in test");
  chk_test_excl: assert property (
    !(pins_tristate_out && nand_tree_mode_out)) else $error("two test modes");
  chk_oper_entry: assert property (
    $rose(pv) && p_op ##1 (pv && p_op) [*8] |-> status_serial_oe_out)
    else $error("operational mode not entered");
  chk_tri_entry: assert property (
    $rose(pv) && p_tr ##1 (pv && p_tr) [*8] |-> pins_tristate_out) else $error("no tristate");
  chk_nand_entry: assert property (
    $rose(pv) && p_nd ##1 (pv && p_nd) [*8] |-> nand_tree_mode_out) else $error("no nand");
  chk_test_pwr: assert property (
    run_tst [*6] |-> power_indicator_out == $past(power_enable_in))
    else $error("power indicator in test");
  chk_test_att: assert property (
    (run_tst && $stable(main_fault_n_in) && $stable(aux_fault_n_in)) [*6]
    |-> attention_indicator_out == ~(main_fault_n_in & aux_fault_n_in))
    else $error("attention indicator in test");
endmodule // hpsc_scan_chain_chk

bind hpsc_scan_chain hpsc_scan_chain_chk u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .main_power_valid_in(main_power_valid_in),
  .test_select_in(test_select_in), .mode_pin_low_in(mode_pin_low_in),
  .mode_pin_high_in(mode_pin_high_in), .status_serial_oe_out(status_serial_oe_out),
  .command_serial_oe_out(command_serial_oe_out), .main_fault_n_in(main_fault_n_in),
  .aux_fault_n_in(aux_fault_n_in), .power_enable_in(power_enable_in),
  .power_indicator_out(power_indicator_out), .attention_indicator_out(attention_indicator_out),
  .pins_tristate_out(pins_tristate_out), .nand_tree_mode_out(nand_tree_mode_out));

// >>> verification/hpsc_ctrl_model.sv
// Hot-plug controller and downstream device model on the status scan link.
`timescale 1ns/10ps
module hpsc_ctrl_model (
  output logic sclk_out,
  output logic frame_out,
  output logic casc_out,
  input  wire  status_in
);
  // Link clock parks low between frames; the frame line idles high.
  initial begin
    sclk_out = 1'b0;
    frame_out = 1'b1;
    casc_out = 1'b0;
  end

  // Start bit, three header bits, then twenty data clocks; idle cascade toggles.
  task automatic run_frame(input [1:0] ch, input [3:0] casc, output [19:0] got);
    for (int k = 0; k < 24; k++) begin
      frame_out = (k == 0) ? 1'b0 : (k == 1) ? ch[0] : (k == 2) ? ch[1] : 1'b1;
      casc_out = (k >= 4 && k < 8) ? casc[k-4] : ~casc_out;
      #80 sclk_out = 1'b1;
      if (k >= 4) got[k-4] = status_in;
      #80 sclk_out = 1'b0;
    end
  endtask
endmodule // hpsc_ctrl_model

// >>> verification/hpsc_scan_chain_bench.sv
// Self-checking bench of the status scan chain.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module hpsc_scan_chain_bench;
  logic        core_clk_in, rst_n_in, reg_write_in, reg_read_in, main_power_valid_in;
  logic        test_select_in, mode_pin_low_in, mode_pin_high_in;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic [29:0] pins;
  wire  [31:0] reg_rdata_out;
  wire         irq_out, status_serial_out, status_serial_oe_out, command_serial_out;
  wire         command_serial_oe_out, pins_tristate_out, nand_tree_mode_out;
  wire         status_frame_line_in, status_scan_clock_in, status_cascade_in_in;
  wire  [1:0]  interlock_open_in, button_pushed_in, main_fault_n_in, aux_fault_n_in;
  wire  [1:0]  present1_in, present2_in, clk66_enable_in, xcap_above_gnd_in, xcap_open_in;
  wire  [1:0]  power_enable_in, slot_clock_enable_in, slot_bus_enable_in, slot_reset_line_in;
  wire  [1:0]  power_indicator_cmd_in, attention_indicator_cmd_in;
  wire  [1:0]  power_indicator_out, attention_indicator_out;
  int          n_fail, cmp_count;

  // Slot pins come from one word so that expectations index it directly.
  assign {interlock_open_in, button_pushed_in, main_fault_n_in, aux_fault_n_in, present1_in,
          present2_in, clk66_enable_in, xcap_above_gnd_in, xcap_open_in, power_enable_in,
          slot_clock_enable_in, slot_bus_enable_in, slot_reset_line_in,
          power_indicator_cmd_in, attention_indicator_cmd_in} = pins;

  hpsc_scan_chain DUT (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .main_power_valid_in(main_power_valid_in),
    .test_select_in(test_select_in), .mode_pin_low_in(mode_pin_low_in),
    .status_serial_out(status_serial_out), .status_serial_oe_out(status_serial_oe_out),
    .mode_pin_high_in(mode_pin_high_in), .command_serial_out(command_serial_out),
    .command_serial_oe_out(command_serial_oe_out), .status_frame_line_in(status_frame_line_in),
    .status_scan_clock_in(status_scan_clock_in), .status_cascade_in_in(status_cascade_in_in),
    .interlock_open_in(interlock_open_in), .button_pushed_in(button_pushed_in),
    .main_fault_n_in(main_fault_n_in), .aux_fault_n_in(aux_fault_n_in),
    .present1_in(present1_in), .present2_in(present2_in), .clk66_enable_in(clk66_enable_in),
    .xcap_above_gnd_in(xcap_above_gnd_in), .xcap_open_in(xcap_open_in),
    .power_enable_in(power_enable_in), .slot_clock_enable_in(slot_clock_enable_in),
    .slot_bus_enable_in(slot_bus_enable_in), .slot_reset_line_in(slot_reset_line_in),
    .power_indicator_cmd_in(power_indicator_cmd_in),
    .attention_indicator_cmd_in(attention_indicator_cmd_in),
    .power_indicator_out(power_indicator_out),
    .attention_indicator_out(attention_indicator_out),
    .pins_tristate_out(pins_tristate_out), .nand_tree_mode_out(nand_tree_mode_out));
  hpsc_ctrl_model CM (.sclk_out(status_scan_clock_in), .frame_out(status_frame_line_in),
                      .casc_out(status_cascade_in_in), .status_in(status_serial_out));

  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // Channel word for both slots; the open capability input implies above ground.
  function automatic [15:0] exp_word(input [1:0] ch);
    logic [29:0] p;
    p = pins;
    exp_word = 16'h0;
    for (int s = 0; s < 2; s++)
      case (ch)
        2'h0: exp_word[8*s+:8] = {3'h0, p[20+s], p[18+s], p[24+s] & p[22+s], p[26+s], p[28+s]};
        2'h1: exp_word[8*s+:8] = {4'h0, p[22+s], p[12+s], p[14+s] | p[12+s], p[16+s]};
        2'h2: exp_word[8*s+:8] = {1'b0, p[s], p[2+s], p[4+s], p[6+s], p[8+s], p[10+s], 1'b1};
        default: exp_word[8*s+:8] = 8'h0;
      endcase
  endfunction

  task automatic wr_reg(input [7:0] a, input [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic chk_rd(input string nm, input [7:0] a, input [31:0] m, input [31:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1 `CHK(nm, e, reg_rdata_out & m)
  endtask

  task automatic pup(input t, input hi, input lo);
    @(posedge core_clk_in);
    main_power_valid_in <= 1'b0;
    test_select_in <= t;
    mode_pin_high_in <= hi;
    mode_pin_low_in <= lo;
    repeat (6) @(posedge core_clk_in);
    main_power_valid_in <= 1'b1;
    repeat (12) @(posedge core_clk_in);
  endtask

  task automatic t_modes;
    pup(1'b1, 1'b0, 1'b1);
    `CHK("tristate", 1'b1, pins_tristate_out)
    chk_rd("mode tri", 8'h00, 32'h7, 32'h3);
    pup(1'b1, 1'b0, 1'b0);
    `CHK("nand", 1'b1, nand_tree_mode_out)
    chk_rd("mode nand", 8'h00, 32'h7, 32'h2);
    pup(1'b0, 1'b1, 1'b0);
    chk_rd("mode rsvd", 8'h00, 32'h7, 32'h4);
    chk_rd("rsvd event", 8'h08, 32'h4, 32'h4);
    $display("modes done");
  endtask

  task automatic t_oper;
    pup(1'b0, 1'b1, 1'b1);
    `CHK("oe", 2'b11, {status_serial_oe_out, command_serial_oe_out})
    `CHK("cmd out", 1'b0, command_serial_out)
    chk_rd("mode oper", 8'h00, 32'h37, 32'h31);
    chk_rd("oper event", 8'h08, 32'h1, 32'h1);
    chk_rd("mask reset", 8'h0c, 32'h7, 32'h0);
    chk_rd("unmapped", 8'h10, 32'hffffffff, 32'h0);
    wr_reg(8'h08, 32'h7);
    $display("operational done");
  endtask

  task automatic t_chan;
    logic [19:0] fr;
    logic [1:0]  ch;
    wr_reg(8'h0c, 32'h2);
    for (int p = 0; p < 2; p++) begin
      @(posedge core_clk_in);
      pins <= p ? 30'h24d24639 : 30'h1b2de9c6;
      repeat (6) @(posedge core_clk_in);
      for (int i = 0; i < 4; i++) begin
        ch = i[1:0];
        @(posedge core_clk_in);
        #3 CM.run_frame(ch, 4'h5 + ch, fr);
        `CHK("frame", {4'h5 + ch, exp_word(ch)}, fr)
        `CHK("irq set", 1'b1, irq_out)
        chk_rd("chan", 8'h04, 32'h7, {29'h0, 1'b1, ch});
        wr_reg(8'h08, 32'h2);
        #1 `CHK("irq clear", 1'b0, irq_out)
      end
    end
    $display("channels done");
  endtask

  task automatic t_test;
    @(posedge core_clk_in);
    test_select_in <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    #1 `CHK("pwr test", pins[11:10], power_indicator_out)
    `CHK("att test", ~(pins[25:24] & pins[23:22]), attention_indicator_out)
    @(posedge core_clk_in);
    test_select_in <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    #1 `CHK("pwr normal", pins[3:2], power_indicator_out)
    `CHK("att normal", pins[1:0], attention_indicator_out)
    $display("run-time test done");
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    {rst_n_in, reg_write_in, reg_read_in, main_power_valid_in} = 4'h0;
    {test_select_in, mode_pin_low_in, mode_pin_high_in} = 3'h0;
    reg_addr_in = 8'h0;
    reg_wdata_in = 32'h0;
    pins = 30'h1b2de9c6;
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_modes;
    t_oper;
    t_chan;
    t_test;
    summarize;
  end

  // Eight frames take about 31 us and the rest a few us; 200 us is ample before a hang.
  initial begin
    #200000;
    n_fail++;
    summarize;
  end
endmodule // hpsc_scan_chain_bench
